// >>> iar_pkg.sv
// package: constants and carriers for the i2c alias remap table
`default_nettype none

package iar_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W = 7;                 // i2c 7-bit address
  localparam int REG_W = 8;                  // slot register width
  localparam int WB_ADR_W = 8;               // wishbone byte address width
  localparam int WB_DAT_W = 32;              // wishbone data width
  localparam int SEL_W = 4;                  // byte selects
  localparam int NUM_SLOTS = 4;              // slots the matcher scans
  localparam int SLOT_W = 3;                 // slot index width (0..7)

  ////////////////////////////////////////////////////////////////////////////
  // register indices as printed; byte address is four times the index
  localparam logic [WB_ADR_W-1:0] IDX_PHYS6 = 8'h0e;
  localparam logic [WB_ADR_W-1:0] IDX_PHYS7 = 8'h0f;
  localparam logic [WB_ADR_W-1:0] IDX_ALIAS0 = 8'h10;
  localparam logic [WB_ADR_W-1:0] IDX_ALIAS1 = 8'h11;
  localparam logic [WB_ADR_W-1:0] ADR_PHYS6 = WB_ADR_W'(IDX_PHYS6 * 4);
  localparam logic [WB_ADR_W-1:0] ADR_PHYS7 = WB_ADR_W'(IDX_PHYS7 * 4);
  localparam logic [WB_ADR_W-1:0] ADR_ALIAS0 = WB_ADR_W'(IDX_ALIAS0 * 4);
  localparam logic [WB_ADR_W-1:0] ADR_ALIAS1 = WB_ADR_W'(IDX_ALIAS1 * 4);

  ////////////////////////////////////////////////////////////////////////////
  // field layout and reset values
  localparam int FLD_HI = 7;                 // address field top bit
  localparam int FLD_LO = 1;                 // address field bottom bit
  localparam int SEL_LANE0 = 0;              // byte lane holding the register
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;   // reset of every slot
  localparam logic [ADDR_W-1:0] ALIAS_OFF = 7'h00;  // alias value that disables
  localparam logic RSVD_BIT = 1'b0;          // reserved bit 0 reads as this
  localparam logic [WB_DAT_W-REG_W-1:0] DAT_PAD = 24'h00_0000;  // upper lanes
  localparam logic [WB_DAT_W-1:0] DAT_ZERO = 32'h0000_0000;     // unmapped read

  ////////////////////////////////////////////////////////////////////////////
  // slot numbers scanned, in priority order (lowest entry wins)
  localparam logic [SLOT_W-1:0] SLOT_0 = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_1 = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_6 = 3'h6;
  localparam logic [SLOT_W-1:0] SLOT_7 = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef logic [ADDR_W-1:0] iar_addr_t;

  typedef struct packed {
    logic valid;                             // one-cycle lookup strobe
    iar_addr_t addr;                         // incoming i2c address
  } iar_lookup_req_s;

  typedef struct packed {
    logic done;                              // one-cycle answer strobe
    logic hit;                               // an enabled alias matched
    logic [SLOT_W-1:0] slot;                 // matched slot number
    iar_addr_t addr;                         // address to forward
  } iar_lookup_rsp_s;

endpackage

`default_nettype wire

// >>> iar_alias_match.sv
// one slot's alias comparator
`default_nettype none

module iar_alias_match (
  input wire iar_pkg::iar_addr_t alias_addr,  // programmed alias of this slot
  input wire iar_pkg::iar_addr_t probe_addr,  // incoming i2c address
  output logic match                          // slot enabled and equal
);

  // a zero alias never matches, so a cleared slot is disabled and remaps nothing
  always_comb begin
    match = (alias_addr != iar_pkg::ALIAS_OFF) && (alias_addr == probe_addr);
  end

endmodule

`default_nettype wire

// >>> iar_remap_table.sv
// i2c alias remap table: wishbone slot registers and alias lookup
`default_nettype none

// Functional notes
// - physical slots hold 7-bit address in bits 7:1
// - matched transaction forwards with slot's physical address
// - alias slots hold 7-bit alias, compared to incoming
// - alias slot n pairs with physical slot n
// - zero alias disables slot, never matches
// - all slot registers reset to zero
module iar_remap_table (
  input wire logic clock,                             // 100 mhz system clock
  input wire logic arst_n,                            // async reset, active low
  // wishbone classic slave
  input wire logic wb_cyc_i,                          // bus cycle
  input wire logic wb_stb_i,                          // strobe
  input wire logic wb_we_i,                           // write enable
  input wire logic [iar_pkg::WB_ADR_W-1:0] wb_adr_i,  // byte address
  input wire logic [iar_pkg::SEL_W-1:0] wb_sel_i,     // byte selects
  input wire logic [iar_pkg::WB_DAT_W-1:0] wb_dat_i,  // write data
  output logic [iar_pkg::WB_DAT_W-1:0] wb_dat_o,      // read data
  output logic wb_ack_o,                              // acknowledge
  // slots held by the neighbouring table
  input wire iar_pkg::iar_addr_t phys_addr_slot0,     // physical address slot 0
  input wire iar_pkg::iar_addr_t phys_addr_slot1,     // physical address slot 1
  input wire iar_pkg::iar_addr_t alias_addr_slot6,    // alias slot 6
  input wire iar_pkg::iar_addr_t alias_addr_slot7,    // alias slot 7
  // own slots, shown to the neighbouring table
  output iar_pkg::iar_addr_t phys_addr_slot6,         // physical address slot 6
  output iar_pkg::iar_addr_t phys_addr_slot7,         // physical address slot 7
  output iar_pkg::iar_addr_t alias_addr_slot0,        // alias slot 0
  output iar_pkg::iar_addr_t alias_addr_slot1,        // alias slot 1
  // lookup from the i2c target front end
  input wire iar_pkg::iar_lookup_req_s lookup_req,    // address to translate
  output iar_pkg::iar_lookup_rsp_s lookup_rsp         // translated answer
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  logic rst_meta_r;                                   // first stage, read only by next
  logic rst_n_r;                                      // synchronised reset

  // assert at once, release after two edges so no flop sees a runt release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave and slot registers
  logic ack_r;                                        // acknowledge flop
  logic ack_nxt;
  logic [iar_pkg::WB_DAT_W-1:0] rdat_r;               // read data flop
  logic [iar_pkg::WB_DAT_W-1:0] rdat_nxt;
  iar_pkg::iar_addr_t phys6_r;                        // physical slot 6 field
  iar_pkg::iar_addr_t phys6_nxt;
  iar_pkg::iar_addr_t phys7_r;                        // physical slot 7 field
  iar_pkg::iar_addr_t phys7_nxt;
  iar_pkg::iar_addr_t alias0_r;                       // alias slot 0 field
  iar_pkg::iar_addr_t alias0_nxt;
  iar_pkg::iar_addr_t alias1_r;                       // alias slot 1 field
  iar_pkg::iar_addr_t alias1_nxt;
  logic req;                                          // request present
  logic wr_commit;                                    // write lands this edge
  iar_pkg::iar_addr_t wr_field;                       // bits 7:1 of write data

  // next state of bus answer and registers
  always_comb begin
    req = wb_cyc_i && wb_stb_i;
    // one wait state: ack goes high the cycle after the request, then drops
    ack_nxt = req && !ack_r;
    // writes take effect on the edge where the master sees ack
    wr_commit = req && wb_we_i && ack_r && wb_sel_i[iar_pkg::SEL_LANE0];
    // bit 0 of the lane is dropped here, so writes to it have no effect
    wr_field = wb_dat_i[iar_pkg::FLD_HI:iar_pkg::FLD_LO];
    phys6_nxt = phys6_r;
    phys7_nxt = phys7_r;
    alias0_nxt = alias0_r;
    alias1_nxt = alias1_r;
    if (wr_commit) begin
      case (wb_adr_i)
        iar_pkg::ADR_PHYS6: begin
          phys6_nxt = wr_field;
        end
        iar_pkg::ADR_PHYS7: begin
          phys7_nxt = wr_field;
        end
        iar_pkg::ADR_ALIAS0: begin
          alias0_nxt = wr_field;
        end
        iar_pkg::ADR_ALIAS1: begin
          alias1_nxt = wr_field;
        end
        default: begin
          // unmapped write: acknowledged and dropped
        end
      endcase
    end
    // read data: field in bits 7:1, bit 0 and upper lanes zero
    rdat_nxt = iar_pkg::DAT_ZERO;
    if (req && !wb_we_i && !ack_r) begin
      case (wb_adr_i)
        iar_pkg::ADR_PHYS6: begin
          rdat_nxt = {iar_pkg::DAT_PAD, phys6_r, iar_pkg::RSVD_BIT};
        end
        iar_pkg::ADR_PHYS7: begin
          rdat_nxt = {iar_pkg::DAT_PAD, phys7_r, iar_pkg::RSVD_BIT};
        end
        iar_pkg::ADR_ALIAS0: begin
          rdat_nxt = {iar_pkg::DAT_PAD, alias0_r, iar_pkg::RSVD_BIT};
        end
        iar_pkg::ADR_ALIAS1: begin
          rdat_nxt = {iar_pkg::DAT_PAD, alias1_r, iar_pkg::RSVD_BIT};
        end
        default: begin
          rdat_nxt = iar_pkg::DAT_ZERO;               // unmapped reads as zero
        end
      endcase
    end else if (ack_r) begin
      rdat_nxt = rdat_r;                              // hold through the ack cycle
    end
  end

  // register the bus answer and slot fields; all slots clear on reset
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      rdat_r <= iar_pkg::DAT_ZERO;
      phys6_r <= iar_pkg::ADDR_RST;
      phys7_r <= iar_pkg::ADDR_RST;
      alias0_r <= iar_pkg::ADDR_RST;
      alias1_r <= iar_pkg::ADDR_RST;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      phys6_r <= phys6_nxt;
      phys7_r <= phys7_nxt;
      alias0_r <= alias0_nxt;
      alias1_r <= alias1_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot table seen by the matcher
  iar_pkg::iar_addr_t alias_tab [iar_pkg::NUM_SLOTS];  // alias per entry
  iar_pkg::iar_addr_t phys_tab [iar_pkg::NUM_SLOTS];   // physical per entry
  logic [iar_pkg::SLOT_W-1:0] slot_tab [iar_pkg::NUM_SLOTS];  // slot number
  logic [iar_pkg::NUM_SLOTS-1:0] match;               // per-entry hit

  // each entry pairs an alias with the physical address of the same slot
  always_comb begin
    alias_tab[0] = alias0_r;
    phys_tab[0] = phys_addr_slot0;
    slot_tab[0] = iar_pkg::SLOT_0;
    alias_tab[1] = alias1_r;
    phys_tab[1] = phys_addr_slot1;
    slot_tab[1] = iar_pkg::SLOT_1;
    alias_tab[2] = alias_addr_slot6;
    phys_tab[2] = phys6_r;
    slot_tab[2] = iar_pkg::SLOT_6;
    alias_tab[3] = alias_addr_slot7;
    phys_tab[3] = phys7_r;
    slot_tab[3] = iar_pkg::SLOT_7;
  end

  // one comparator per entry
  for (genvar g = 0; g < iar_pkg::NUM_SLOTS; g++) begin : g_slot
    iar_alias_match u_match (
      .alias_addr(alias_tab[g]),
      .probe_addr(lookup_req.addr),
      .match(match[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // lookup answer
  iar_pkg::iar_lookup_rsp_s rsp_r;                    // registered answer
  iar_pkg::iar_lookup_rsp_s rsp_nxt;

  // lowest entry wins if software programmed the same alias twice;
  // a miss forwards nothing remapped and echoes the original address
  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.done = lookup_req.valid;
    rsp_nxt.addr = lookup_req.addr;
    if (lookup_req.valid) begin
      for (int i = iar_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
        if (match[i]) begin
          rsp_nxt.hit = 1'b1;
          rsp_nxt.slot = slot_tab[i];
          rsp_nxt.addr = phys_tab[i];
        end
      end
    end
  end

  // answer stands one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each from a flop
  always_comb begin
    wb_ack_o = ack_r;
    wb_dat_o = rdat_r;
    phys_addr_slot6 = phys6_r;
    phys_addr_slot7 = phys7_r;
    alias_addr_slot0 = alias0_r;
    alias_addr_slot1 = alias1_r;
    lookup_rsp = rsp_r;
  end

endmodule

`default_nettype wire

// >>> iar_remap_table_asserts.sv
// checker: port-level properties of the alias remap table
`default_nettype none
module iar_remap_table_asserts (
  input wire logic clock,  // system clock
  input wire logic arst_n,  // async reset, active low
  input wire logic wb_cyc_i,  // bus cycle
  input wire logic wb_stb_i,  // strobe
  input wire logic wb_we_i,  // write enable
  input wire logic [iar_pkg::WB_ADR_W-1:0] wb_adr_i,  // byte address
  input wire logic [iar_pkg::SEL_W-1:0] wb_sel_i,  // byte selects
  input wire logic [iar_pkg::WB_DAT_W-1:0] wb_dat_i,  // write data
  input wire logic [iar_pkg::WB_DAT_W-1:0] wb_dat_o,  // read data
  input wire logic wb_ack_o,  // acknowledge
  input wire iar_pkg::iar_addr_t phys_addr_slot0,  // neighbour physical 0
  input wire iar_pkg::iar_addr_t phys_addr_slot1,  // neighbour physical 1
  input wire iar_pkg::iar_addr_t phys_addr_slot6,  // own physical 6
  input wire iar_pkg::iar_addr_t alias_addr_slot0,  // own alias 0
  input wire iar_pkg::iar_addr_t alias_addr_slot1,  // own alias 1
  input wire iar_pkg::iar_lookup_req_s lookup_req,  // lookup strobe
  input wire iar_pkg::iar_lookup_rsp_s lookup_rsp  // lookup answer
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic req;  // fresh bus request, not yet answered
  logic wr;  // write accepted on this edge
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  // an enabled alias match forwards the paired physical address
  property hit_p(iar_pkg::iar_addr_t al, iar_pkg::iar_addr_t ph, logic [2:0] s, logic ok);
    lookup_req.valid && ok && al != 7'h00 && lookup_req.addr == al |=>
      lookup_rsp.hit && lookup_rsp.slot == s && lookup_rsp.addr == $past(ph);
  endproperty
  ack_follows_a: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged after one cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  read_rsvd_a: assert property (wb_ack_o && !wb_we_i |->
    wb_dat_o[0] == 1'b0 && wb_dat_o[31:8] == 24'h00_0000)
    else $error("reserved read bits not zero");
  phys6_write_a: assert property (wr && wb_adr_i == iar_pkg::ADR_PHYS6 |=>
    phys_addr_slot6 == $past(wb_dat_i[7:1]))
    else $error("physical slot 6 not written from bits 7:1");
  alias0_write_a: assert property (wr && wb_adr_i == iar_pkg::ADR_ALIAS0 |=>
    alias_addr_slot0 == $past(wb_dat_i[7:1]))
    else $error("alias slot 0 not written from bits 7:1");
  alias0_hit_a: assert property (
    hit_p(alias_addr_slot0, phys_addr_slot0, 3'h0, 1'b1))
    else $error("alias 0 match not remapped to physical 0");
  alias1_hit_a: assert property (
    hit_p(alias_addr_slot1, phys_addr_slot1, 3'h1, lookup_req.addr != alias_addr_slot0))
    else $error("alias 1 match not remapped to physical 1");
  zero_never_a: assert property (lookup_req.valid && lookup_req.addr == 7'h00 |=>
    lookup_rsp.done && !lookup_rsp.hit)
    else $error("zero address matched a slot");
  reset_clear_a: assert property ($rose(arst_n) |->
    phys_addr_slot6 == 7'h00 && alias_addr_slot0 == 7'h00 && alias_addr_slot1 == 7'h00)
    else $error("slot not cleared by reset");
  cover property (lookup_rsp.hit);
  cover property (lookup_req.valid && lookup_req.addr == 7'h00);
  cover property (wr);
endmodule
bind iar_remap_table iar_remap_table_asserts chk_u (.*);
`default_nettype wire

// >>> iar_front_model.sv
// partner model: i2c front end asking the table for address lookups
`default_nettype none
module iar_front_model (
  input wire logic clock,  // system clock
  input wire logic arst_n,  // async reset, active low
  input wire logic go,  // bench asks for one lookup
  input wire iar_pkg::iar_addr_t probe,  // address to translate
  output iar_pkg::iar_lookup_req_s lookup_req,  // one-cycle strobe
  input wire iar_pkg::iar_lookup_rsp_s lookup_rsp,  // answer
  output iar_pkg::iar_lookup_rsp_s got  // last answer, kept
);
  timeunit 1ns;
  timeprecision 1ps;
  // answer cleared on each new strobe so a missing reply cannot pass as stale
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lookup_req <= '0;
      got <= '0;
    end else begin
      lookup_req <= '{valid: go, addr: probe};
      if (lookup_req.valid) got <= '0;
      else if (lookup_rsp.done) got <= lookup_rsp;
    end
  end
endmodule
`default_nettype wire

// >>> iar_remap_table_test.sv
// testbench: random register traffic and lookups on the alias remap table
`default_nettype none
module iar_remap_table_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, go = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dout, q, seed;
  iar_pkg::iar_addr_t ph0 = '0, ph1 = '0, al6 = '0, al7 = '0, probe = '0;
  iar_pkg::iar_addr_t er[4];  // expected phys6, phys7, alias0, alias1
  iar_pkg::iar_lookup_req_s req;
  iar_pkg::iar_lookup_rsp_s rsp, got;
  logic [7:0] adrs[4] = '{iar_pkg::ADR_PHYS6, iar_pkg::ADR_PHYS7, iar_pkg::ADR_ALIAS0,
    iar_pkg::ADR_ALIAS1};
  iar_pkg::iar_addr_t p6, p7, a0, a1;  // own slot outputs of the table
  int checks = 0, bad_count = 0;
  always #5 clock = ~clock;
  iar_remap_table dut_u (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
    .wb_ack_o(ack), .phys_addr_slot0(ph0), .phys_addr_slot1(ph1), .alias_addr_slot6(al6),
    .alias_addr_slot7(al7), .phys_addr_slot6(p6), .phys_addr_slot7(p7), .alias_addr_slot0(a0),
    .alias_addr_slot1(a1), .lookup_req(req), .lookup_rsp(rsp));
  iar_front_model fm_u (.clock(clock), .arst_n(arst_n), .go(go), .probe(probe),
    .lookup_req(req), .lookup_rsp(rsp), .got(got));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected answer: slots scanned 0,1,6,7; a zero alias never matches
  function automatic iar_pkg::iar_lookup_rsp_s exp_lk(iar_pkg::iar_addr_t a);
    iar_pkg::iar_lookup_rsp_s r;
    r = '{done: 1'b1, hit: 1'b0, slot: 3'h0, addr: a};
    if (er[2] != 0 && er[2] == a) r = '{1'b1, 1'b1, 3'h0, ph0};
    else if (er[3] != 0 && er[3] == a) r = '{1'b1, 1'b1, 3'h1, ph1};
    else if (al6 != 0 && al6 == a) r = '{1'b1, 1'b1, 3'h6, er[0]};
    else if (al7 != 0 && al7 == a) r = '{1'b1, 1'b1, 3'h7, er[1]};
    return r;
  endfunction
  task automatic print_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dout;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask
  // one lookup through the front-end model; answer checked four cycles after go drops, latency not measured
  task automatic look(input iar_pkg::iar_addr_t a);
    @(posedge clock);
    go <= 1'b1;
    probe <= a;
    @(posedge clock);
    go <= 1'b0;
    repeat (4) @(posedge clock);
    chk({20'h0_0000, got}, {20'h0_0000, exp_lk(a)});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'd88465;
    er = '{default: '0};
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, adrs[i], 32'h0, 4'hf);
      chk(q, 32'h0);
    end
    wb(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(q, 32'h0);
    for (int r = 0; r < 12; r++) begin
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        if (seed[9] || r == 0) er[i] = seed[7:1];
        wb(1'b1, adrs[i], seed, {3'h0, seed[9] || r == 0});
        wb(1'b0, adrs[i], ~seed, 4'hf);
        chk(q, {24'h00_0000, er[i], 1'b0});
      end
      // the slot outputs must mirror the registers, slot 7 included
      chk({4'h0, p6, p7, a0, a1}, {4'h0, er[0], er[1], er[2], er[3]});
      {ph0, ph1, al6, al7} <= seed[27:0];
      look(er[2]);
      look(er[3]);
      look(al6);
      look(al7);
      look(seed[6:0]);
    end
    wb(1'b1, iar_pkg::ADR_ALIAS0, 32'h0, 4'h1);
    er[2] = '0;
    look(7'h00);
    // mid-run reset: slots hold programmed values, all must clear again
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk({4'h0, p6, p7, a0, a1}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, adrs[i], 32'h0, 4'hf);
      chk(q, 32'h0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
